//--- ccm_cfg.svh
/*
 * constants of the capture/compare/pwm mode control block: mode codes,
 * register byte offsets and field widths.
 * assumes: included by its bare name from the package only; the design uses its macros.
 */
//
// Notes on behaviour
// RULE_01: mode 0000 turns off, resets internal state
// RULE_02: 0100-0111 capture fall, rise, 4th, 16th rise
// RULE_03: 0010 toggles pin and sets flag on match
// RULE_04: 1000 sets pin, 1001 clears pin, flag set
// RULE_05: 1010 only sets flag, pin untouched
// RULE_06: 1011 flag, timer reset, conversion start
// RULE_07: only second instance requests conversion start
// RULE_08: 11xx is pwm; duty low bits 5:4
// RULE_09: 0001 and 0011 reserved, select nothing
// RULE_10: control bits 7:6 always read zero
// RULE_11: capture copies full 16-bit count to pair
// RULE_12: capture sets flag; only software clears it
// RULE_13: new capture overwrites pair, no overrun flag
// RULE_14: edge detector watches pin even when output
// RULE_15: software keeps timebase synchronous for capture
// RULE_16: mode change may raise spurious flag
// RULE_17: prescaler cleared when off, non-capture, reset
// RULE_18: switching prescalers keeps counter; write zero first
// RULE_19: instances share one timebase count each
// RULE_20: special event cleared count seen by other
// RULE_21: capture/compare use timebase, pwm other timer
// RULE_22: compare pair against count, match on equality
// RULE_23: special event immediate; count cleared next tick
// RULE_24: writing zero forces compare output low
// RULE_25: special event never sets overflow flag
// RULE_26: pin synchronised before edge detection
// RULE_27: prescaler counts rises, captures on 4/16
// RULE_28: pair holds while off or comparing
// RULE_29: compare flag set once per match
// RULE_30: reserved writes ignored; reserved modes inert
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define CCM_MODE_OFF      4'h0
`define CCM_MODE_TOGGLE   4'h2
`define CCM_MODE_CAP_FALL 4'h4
`define CCM_MODE_CAP_RISE 4'h5
`define CCM_MODE_CAP_DIV4 4'h6
`define CCM_MODE_CAP_D16  4'h7
`define CCM_MODE_SET      4'h8
`define CCM_MODE_CLEAR    4'h9
`define CCM_MODE_SOFT     4'ha
`define CCM_MODE_SPECIAL  4'hb
`define CCM_GRP_CAPTURE   2'h1
`define CCM_GRP_PWM       2'h3
`define CCM_PSC_LAST4     4'h3
`define CCM_PSC_LAST16    4'hf

// ---------------------------------------------------------------
// register map, byte addresses
// ---------------------------------------------------------------
`define CCM_OFS_CTRL      8'h00
`define CCM_OFS_LOW       8'h04
`define CCM_OFS_HIGH      8'h08
`define CCM_INST_STRIDE   8'h0c
`define CCM_OFS_FLAGS     8'h18
`define CCM_OFS_STATUS    8'h1c
`define CCM_CTRL_W        6
`define CCM_ADDR_W        8

`endif

//--- ccm_pkg.sv
/*
 * types of the capture/compare/pwm mode control block.
 * assumes: ccm_cfg.svh is on the include path.
 */
package ccm_pkg;
`include "ccm_cfg.svh"

	typedef struct packed {
		logic       on;      // instance is in a pwm mode
		logic [9:0] duty;    // ten-bit duty value
	} ccm_pwm_t;

	typedef struct packed {
		logic [`CCM_CTRL_W-1:0] ctrl;    // duty low bits and mode
		logic [15:0]            ccpr;    // capture/compare pair
		logic                   flag;    // event flag
		logic                   cmp_out; // compare output latch
		logic                   oe_n;    // pin drive enable, low
		logic [3:0]             psc;     // capture prescaler
		logic [2:0]             sync;    // pin synchroniser
		logic                   level;   // filtered pin level
		logic                   match_q; // match seen last cycle
		logic                   spec;    // special event pulse
		ccm_pwm_t               pwm;     // pwm duty output
	} ccm_inst_t;

	typedef struct packed {
		ccm_inst_t [1:0]         inst;
		logic                    wr_pend;   // write data phase due
		logic [`CCM_ADDR_W-1:0]  wr_addr;   // latched byte address
		logic [31:0]             rdata;     // read data
		logic                    ready;     // hreadyout
		logic                    resp;      // hresp
		logic                    tmr_rst;   // timebase clear request
		logic                    adc_start; // conversion start
	} ccm_state_t;

endpackage : ccm_pkg

//--- ccm_top.sv
/*
 * mode control, capture and compare paths of two capture/compare/pwm
 * instances sharing one timebase count, with an ahb-lite register slave.
 * assumes: the timebase and pwm timer live outside; the timebase count
 * arrives on hclk; zero-wait single word transfers.
 */
`timescale 1ns/10ps
module ccm_top
	import ccm_pkg::*;
(
	input  wire logic            hclk,              // bus clock
	input  wire logic            hresetn,           // async reset, low
	input  wire logic            hsel,              // slave select
	input  wire logic [31:0]     haddr,             // byte address
	input  wire logic [1:0]      htrans,            // transfer type
	input  wire logic            hwrite,            // write transfer
	input  wire logic [2:0]      hsize,             // transfer size
	input  wire logic [31:0]     hwdata,            // write data
	input  wire logic            hready,            // bus ready
	output logic [31:0]          hrdata,            // read data
	output logic                 hreadyout,         // slave ready
	output logic                 hresp,             // always okay
	input  wire logic [15:0]     shared_timebase_count, // shared count
	input  wire logic            adc_enable,        // converter on
	input  wire logic [1:0]      pin_direction_bit, // 1 = pin input
	input  wire logic [1:0]      event_pin_in,      // pin levels
	output logic [1:0]           event_pin_out,     // compare latch
	output logic [1:0]           event_pin_oe_n,    // drive enable, low
	output logic [1:0]           event_flag,        // sticky flags
	output logic [1:0]           special_event,     // match pulse
	output logic                 timebase_reset_req, // clear count
	output logic                 adc_start_req,     // start conversion
	output ccm_pkg::ccm_pwm_t [1:0] pwm_duty        // pwm duty values
);
	import ccm_pkg::*;

	ccm_state_t s_reg;
	ccm_state_t s_next;

	// ---------------------------------------------------------------
	// read decode
	// ---------------------------------------------------------------
	function automatic logic [31:0] rd_word(
		input ccm_state_t             st,
		input logic [`CCM_ADDR_W-1:0] a
	);
		logic [31:0] w;
		logic [`CCM_ADDR_W-1:0] base;
		w = 32'h0;
		for (int k = 0; k < 2; k++) begin
			base = (k == 0) ? 8'h00 : `CCM_INST_STRIDE;
			// bits 7:6 of control are never stored: read zero, see RULE_10
			if (a == base + `CCM_OFS_CTRL)
				w = {26'h0, st.inst[k].ctrl};
			if (a == base + `CCM_OFS_LOW)
				w = {24'h0, st.inst[k].ccpr[7:0]};
			if (a == base + `CCM_OFS_HIGH)
				w = {24'h0, st.inst[k].ccpr[15:8]};
		end
		if (a == `CCM_OFS_FLAGS)
			w = {30'h0, st.inst[1].flag, st.inst[0].flag};
		if (a == `CCM_OFS_STATUS)
			w = {28'h0, st.inst[1].level, st.inst[0].level,
			     st.inst[1].cmp_out, st.inst[0].cmp_out};
		return w;
	endfunction : rd_word

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [3:0]             mode;
		logic                   cap_grp;
		logic                   cmp_grp;
		logic                   new_lvl;
		logic                   rise;
		logic                   fall;
		logic                   trig;
		logic                   match;
		logic                   hit;
		logic                   set_flag;
		logic                   clr_flag;
		logic [`CCM_ADDR_W-1:0] base;
		logic [`CCM_ADDR_W-1:0] wa;
		logic [3:0]             wmode;

		mode     = 4'h0;
		cap_grp  = 1'b0;
		cmp_grp  = 1'b0;
		new_lvl  = 1'b0;
		rise     = 1'b0;
		fall     = 1'b0;
		trig     = 1'b0;
		match    = 1'b0;
		hit      = 1'b0;
		set_flag = 1'b0;
		clr_flag = 1'b0;
		base     = 8'h00;
		wa       = s_reg.wr_addr;
		wmode    = hwdata[3:0];

		s_next           = s_reg;
		s_next.ready     = 1'b1;
		s_next.resp      = 1'b0;
		s_next.tmr_rst   = 1'b0;
		s_next.adc_start = 1'b0;

		// address phase: reads are decoded here so hrdata is a flop
		if (hready && hsel && htrans[1]) begin
			s_next.wr_pend = hwrite;
			s_next.wr_addr = haddr[`CCM_ADDR_W-1:0];
			s_next.rdata   = hwrite ? 32'h0 : rd_word(s_reg,
			                 haddr[`CCM_ADDR_W-1:0]);
		end else begin
			s_next.wr_pend = 1'b0;
		end

		for (int i = 0; i < 2; i++) begin
			base    = (i == 0) ? 8'h00 : `CCM_INST_STRIDE;
			mode    = s_reg.inst[i].ctrl[3:0];
			cap_grp = (mode[3:2] == `CCM_GRP_CAPTURE);
			cmp_grp = (mode == `CCM_MODE_TOGGLE) ||
			          (mode[3:2] == 2'h2);
			set_flag = 1'b0;
			clr_flag = 1'b0;
			trig     = 1'b0;
			hit      = 1'b0;

			// three-stage synchroniser; a change counts once the last
			// two stages agree, see RULE_26
			s_next.inst[i].sync = {s_reg.inst[i].sync[1:0],
			                       event_pin_in[i]}; // see RULE_14
			new_lvl = (s_reg.inst[i].sync[1] == s_reg.inst[i].sync[2])
			        ? s_reg.inst[i].sync[2] : s_reg.inst[i].level;
			s_next.inst[i].level = new_lvl;
			rise = new_lvl & ~s_reg.inst[i].level;
			fall = ~new_lvl & s_reg.inst[i].level;

			// capture qualification
			unique case (mode)
				`CCM_MODE_CAP_FALL: trig = fall; // see RULE_02
				`CCM_MODE_CAP_RISE: trig = rise;
				`CCM_MODE_CAP_DIV4, `CCM_MODE_CAP_D16: begin
					// counter survives a jump between dividers, see RULE_18
					if (rise) begin
						if (s_reg.inst[i].psc == ((mode == `CCM_MODE_CAP_DIV4)
						    ? `CCM_PSC_LAST4 : `CCM_PSC_LAST16)) begin
							trig = 1'b1; // see RULE_27
							s_next.inst[i].psc = 4'h0;
						end else begin
							s_next.inst[i].psc = s_reg.inst[i].psc + 4'h1;
						end
					end
				end
				default: trig = 1'b0;
			endcase
			if (!cap_grp)
				s_next.inst[i].psc = 4'h0; // see RULE_17

			// compare against the one shared count, see RULE_19 RULE_21
			match = cmp_grp &&
			        (s_reg.inst[i].ccpr == shared_timebase_count); // see RULE_22
			hit   = match & ~s_reg.inst[i].match_q; // see RULE_29
			s_next.inst[i].match_q = match;
			s_next.inst[i].spec    = 1'b0;

			if (hit) begin
				set_flag = 1'b1; // see RULE_03 RULE_04 RULE_05
				unique case (mode)
					`CCM_MODE_TOGGLE:
						s_next.inst[i].cmp_out = ~s_reg.inst[i].cmp_out;
					`CCM_MODE_SET:   s_next.inst[i].cmp_out = 1'b1;
					`CCM_MODE_CLEAR: s_next.inst[i].cmp_out = 1'b0;
					`CCM_MODE_SPECIAL: begin
						// pulse now; the timer clears on its next tick, and
						// its overflow flag is not involved, see RULE_23 RULE_25
						s_next.inst[i].spec = 1'b1;
						s_next.tmr_rst      = 1'b1; // see RULE_06
						if (i == 1)
							s_next.adc_start = adc_enable; // see RULE_07
					end
					default: s_next.inst[i].cmp_out = s_reg.inst[i].cmp_out;
				endcase
			end

			// mode off: internal state back to reset, see RULE_01
			// reserved codes fall through every branch above, see RULE_09
			if (mode == `CCM_MODE_OFF) begin
				s_next.inst[i].cmp_out = 1'b0;
				s_next.inst[i].match_q = 1'b0;
			end

			// pwm: duty is ccpr low byte with control bits 5:4, see RULE_08
			s_next.inst[i].pwm.on   = (mode[3:2] == `CCM_GRP_PWM);
			s_next.inst[i].pwm.duty = {s_reg.inst[i].ccpr[7:0],
			                           s_reg.inst[i].ctrl[5:4]};

			s_next.inst[i].oe_n = pin_direction_bit[i];

			// software writes in the data phase
			if (s_reg.wr_pend) begin
				if (wa == base + `CCM_OFS_CTRL) begin
					// bits 7:6 dropped, see RULE_10 RULE_30
					s_next.inst[i].ctrl = hwdata[`CCM_CTRL_W-1:0];
					if (wmode == `CCM_MODE_OFF)
						s_next.inst[i].cmp_out = 1'b0; // see RULE_24
				end
				if (wa == base + `CCM_OFS_LOW)
					s_next.inst[i].ccpr[7:0] = hwdata[7:0];
				if (wa == base + `CCM_OFS_HIGH)
					s_next.inst[i].ccpr[15:8] = hwdata[7:0];
				if (wa == `CCM_OFS_FLAGS)
					clr_flag = hwdata[i]; // see RULE_12
			end

			// capture wins over a software write to the same pair; pair
			// otherwise holds when off or comparing, see RULE_28
			if (trig) begin
				// whole 16-bit count, overwrite without overrun, see RULE_11
				// a cleared shared count is captured as is, see RULE_20
				s_next.inst[i].ccpr = shared_timebase_count; // see RULE_13
				set_flag = 1'b1;
			end

			// set beats clear in the same cycle, see RULE_12 RULE_16
			s_next.inst[i].flag = (s_reg.inst[i].flag & ~clr_flag) |
			                      set_flag;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			for (int i = 0; i < 2; i++) begin
				s_reg.inst[i].oe_n <= 1'b1;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from the state register
	// ---------------------------------------------------------------
	always_comb begin
		hrdata             = s_reg.rdata;
		hreadyout          = s_reg.ready;
		hresp              = s_reg.resp;
		timebase_reset_req = s_reg.tmr_rst;
		adc_start_req      = s_reg.adc_start;
		for (int i = 0; i < 2; i++) begin
			event_pin_out[i]  = s_reg.inst[i].cmp_out;
			event_pin_oe_n[i] = s_reg.inst[i].oe_n;
			event_flag[i]     = s_reg.inst[i].flag;
			special_event[i]  = s_reg.inst[i].spec;
			pwm_duty[i]       = s_reg.inst[i].pwm;
		end
	end

endmodule : ccm_top

//--- ccm_pin_model.sv
/*
 * behavioural source of the two event pin levels.
 * assumes: the bench sets want and lag just after a rising edge.
 */
`timescale 1ns/10ps
module ccm_pin_model (
	input  wire logic       hclk, // bench clock
	input  wire logic [1:0] want, // requested levels
	input  wire logic [3:0] lag,  // edges before change
	output logic      [1:0] pin   // driven levels
);
	initial pin = 2'h0;
	// lands mid-cycle on purpose: the pin is asynchronous to hclk
	always @(want) begin
		repeat (lag) @(posedge hclk);
		#7 pin = want;
	end
endmodule : ccm_pin_model

//--- ccm_top_properties.sv
/*
 * port assertions of ccm_top, bound to every instance.
 * assumes: one clock, zero-wait bus, flags clear register at 0x18.
 */
`timescale 1ns/10ps
module ccm_top_properties (
	input wire logic        hclk,               // bus clock
	input wire logic        hresetn,            // reset, low
	input wire logic        hsel,               // slave select
	input wire logic [31:0] haddr,              // byte address
	input wire logic [1:0]  htrans,             // transfer type
	input wire logic        hwrite,             // write
	input wire logic        hready,             // bus ready
	input wire logic        adc_enable,         // converter on
	input wire logic [1:0]  event_pin_out,      // compare latch
	input wire logic [1:0]  event_flag,         // sticky flags
	input wire logic [1:0]  special_event,      // match pulse
	input wire logic        timebase_reset_req, // clear count
	input wire logic        adc_start_req       // conversion start
);
	// a flag clear takes effect one edge after its address phase
	logic clr_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			clr_q <= 1'b0;
		else
			clr_q <= hsel && hready && htrans[1] && hwrite
				&& haddr[7:0] == 8'h18;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_tbrst; timebase_reset_req == (|special_event); endproperty
	a_tbrst: assert property (p_tbrst)
		else $error("timebase clear without special event");
	property p_pulse; special_event[0] |=> !special_event[0]; endproperty
	a_pulse: assert property (p_pulse)
		else $error("special event longer than one cycle");
	property p_adc_src; adc_start_req |-> special_event[1]; endproperty
	a_adc_src: assert property (p_adc_src)
		else $error("conversion start not from second instance");
	property p_adc_en;
		special_event[1] |-> adc_start_req == adc_enable;
	endproperty
	a_adc_en: assert property (p_adc_en)
		else $error("conversion start ignores converter enable");
	property p_sticky; $fell(event_flag[0]) |-> $past(clr_q); endproperty
	a_sticky: assert property (p_sticky)
		else $error("event flag dropped without software clear");
	property p_pin_rise;
		$rose(event_pin_out[0]) |-> event_flag[0];
	endproperty
	a_pin_rise: assert property (p_pin_rise)
		else $error("compare output rose without flag");
	property p_spec_flag; special_event[0] |-> event_flag[0]; endproperty
	a_spec_flag: assert property (p_spec_flag)
		else $error("special event without flag");
	property p_spec_pin;
		special_event[0] |-> $stable(event_pin_out[0]);
	endproperty
	a_spec_pin: assert property (p_spec_pin)
		else $error("special event moved the output pin");
endmodule : ccm_top_properties

bind ccm_top ccm_top_properties u_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .adc_enable(adc_enable),
	.event_pin_out(event_pin_out), .event_flag(event_flag),
	.special_event(special_event), .timebase_reset_req(timebase_reset_req),
	.adc_start_req(adc_start_req));

//--- ccm_top_tb.sv
/*
 * self-checking bench of ccm_top: ahb-lite register tasks, capture
 * through a pin model, compare modes through the shared count.
 * assumes: zero-wait slave, flags clear at 0x18, status at 0x1c.
 */
`timescale 1ns/10ps
module ccm_top_tb;
	import ccm_pkg::*;
	logic        hclk = 0, hresetn = 0, hwrite = 0, adc_en = 1;
	logic        rdy, rsp, trr, adc;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0]  htrans = 0, dir = 2'h3, want = 0, pin, lvl;
	logic [1:0]  pout, poe, flg, spc;
	logic [15:0] cnt = 0;
	logic [3:0]  lag = 4'h1;
	ccm_pwm_t [1:0] pwm;
	int          fail_count = 0, comparisons = 0, cyc = 0, n;
	int          cm [7] = '{8, 10, 11, 9, 2, 1, 3};
	logic [6:0]  ep = 7'b1110111, ef = 7'b0011111;
	// the wire level: whoever is enabled drives it
	assign lvl = (poe & pin) | (~poe & pout);
	ccm_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(rsp),
		.shared_timebase_count(cnt), .adc_enable(adc_en),
		.pin_direction_bit(dir), .event_pin_in(lvl), .event_pin_out(pout),
		.event_pin_oe_n(poe), .event_flag(flg), .special_event(spc),
		.timebase_reset_req(trr), .adc_start_req(adc), .pwm_duty(pwm));
	ccm_pin_model PIN (.hclk(hclk), .want(want), .lag(lag), .pin(pin));
	always #10 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic close_out;
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task automatic pinset(input logic v);
		@(posedge hclk);
		want[0] <= v;
		repeat (8) @(posedge hclk);
	endtask : pinset
	task automatic hit;
		@(posedge hclk);
		cnt <= 16'h0100;
		@(posedge hclk);
		cnt <= 16'h0;
		repeat (3) @(posedge hclk);
	endtask : hit
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h00, 32'h0);
		wr(8'h00, 32'hff);
		rd(8'h00, 32'h3f);
		rd(8'h40, 32'h0);
		wr(8'h04, 32'hab);
		// duty follows the pair one edge after the write lands
		repeat (2) @(posedge hclk);
		chk(pwm[0], {1'b1, 8'hab, 2'h3});
		for (int m = 4; m < 8; m++) begin
			n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
			lag <= (m > 5) ? 4'h3 : 4'h1;
			cnt <= {4'h0, 4'(m), 8'h5a};
			wr(8'h00, 32'h0);
			wr(8'h00, m);
			wr(8'h18, 32'h3);
			for (int k = 1; k <= n; k++) begin
				pinset(1'b1);
				chk(flg[0], m != 4 && k == n);
				pinset(1'b0);
				chk(flg[0], k == n);
			end
			rd(8'h08, m);
		end
		cnt <= 16'hbeef;
		wr(8'h00, 32'h5);
		pinset(1'b1);
		rd(8'h04, 32'hef);
		rd(8'h08, 32'hbe);
		cnt <= 16'h0;
		dir <= 2'h2;
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h1);
		wr(8'h10, 32'h0);
		wr(8'h14, 32'h1);
		wr(8'h0c, 32'hb);
		for (int i = 0; i < 7; i++) begin
			wr(8'h00, cm[i]);
			wr(8'h18, 32'h3);
			adc_en <= i[0];
			hit();
			chk(flg[0], ef[i]);
			chk(pout[0], ep[i]);
			rd(8'h1c, {1'b0, ep[i], 1'b0, ep[i]});
		end
		wr(8'h00, 32'h0);
		@(posedge hclk);
		chk(pout[0], 1'b0);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h0c, 32'h0);
		close_out();
	end
endmodule : ccm_top_tb
